// File: hdl/pnp_cfg_pkg.sv
// Types shared by the configuration register file.
package pnp_cfg_pkg;
  typedef enum logic [1:0] {
    bank_fir_sp2,
    bank_sp1,
    bank_gpio,
    bank_none
  } bank_t;
  typedef enum logic [1:0] {
    test_normal,
    test_float,
    test_xor,
    test_reserved
  } test_mode_t;
endpackage : pnp_cfg_pkg

// File: hdl/pnp_cfg_regs.svh
// Offsets, field positions, reset values and address constants of the configuration file.
`ifndef PNP_CFG_REGS_SVH
`define PNP_CFG_REGS_SVH
`define IDX_UNIT_SELECT 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_NUMBER 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_DMA_FIRST 8'h74
`define IDX_DMA_SECOND 8'h75
`define IDX_BANK_START 8'h30
`define ADDR_PAIR_LOW 16'h002e
`define ADDR_PAIR_HIGH 16'h164e
`define RST_POINTER 8'h00
`define RST_UNIT 8'h00
`define RST_DMA 3'h4
`define RD_UNMAPPED 8'h00
`define RD_NO_DMA 8'h04
`define UNIT_FIR_SP2 8'h02
`define UNIT_SP1 8'h03
`define UNIT_GPIO 8'h07
`define BIT_ACTIVATE 0
`define BIT_IRQ_POL 1
`define BIT_IRQ_TYPE 0
`endif

// File: hdl/pnp_config_register_file.sv
// Plug-and-play configuration register file behind an index/data byte pair.
//
// Behaviour
// - Base strap picks pair 2Eh or 164Eh.
// - Index pointer reads back, resets 00h.
// - Data byte accesses register pointed to.
// - Index 07h holds the logical unit number.
// - Index 30h and above reach selected bank.
// - Unit and global registers unbanked; four banks.
// - Units 02h, 03h, 07h; others reserved.
// - Unimplemented ignore writes; read 00h, 74h/75h 04h.
// - Accesses accepted from the second clock after reset ends, once straps are taken.
// - Reserved bits read zero; host uses RMW.
// - Index 30h bit 0 activates the unit.
// - 60h/61h hold base address high/low.
// - 70h bits 3-0 select interrupt line.
// - 71h bit1 polarity, bit0 edge/level type.
// - Fixed-type units make type bit read-only.
// - 74h bits 2-0 first DMA channel.
// - 75h bits 2-0 second DMA channel.
// - Test straps latched: normal, float, xor, reserved.
// - Float mode releases every signal pin.
// - Xor mode chains all pins into output.
// - Activation attaches IRQ number and DMA channels; bank stays accessible.
// - Hardware reset loads every default.
`timescale 1ns/1ps
`include "pnp_cfg_regs.svh"
`default_nettype none
module pnp_config_register_file #(
  parameter int NUM_BANKS = 4,
  parameter int XOR_PINS = 16,
  // Per-bank 1 marks a unit whose interrupt type is fixed.
  parameter logic [3:0] FIXED_TYPE = 4'h0,
  parameter logic [3:0] FIXED_TYPE_VAL = 4'h0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Straps, sampled on the first clock after reset release.
  input wire logic config_base_strap,
  input wire logic test_strap,
  input wire logic float_select_strap,
  // Decoded 8-bit host I/O cycle.
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_claim,
  output logic [7:0] io_rdata,
  // Per-unit configuration outputs.
  output logic [NUM_BANKS-1:0] unit_active,
  output logic [NUM_BANKS*16-1:0] unit_io_base,
  output logic [NUM_BANKS*4-1:0] unit_irq_num,
  output logic [NUM_BANKS-1:0] unit_irq_pol,
  output logic [NUM_BANKS-1:0] unit_irq_level,
  output logic [NUM_BANKS*3-1:0] unit_dma0,
  output logic [NUM_BANKS*3-1:0] unit_dma1,
  // Board test.
  input wire logic [XOR_PINS-1:0] xor_chain_in,
  output logic all_pins_floated_mode,
  output logic xor_mode,
  output logic xor_out,
  output logic [15:0] cfg_base_addr
);

  // The unit map and the two-bit bank select only serve exactly four banks.
  if (NUM_BANKS != 4) begin : g_bad_banks
    $error("NUM_BANKS must be 4");
  end
  // An empty chain would leave the chain output without a source.
  if (XOR_PINS < 1) begin : g_bad_chain
    $error("XOR_PINS must be positive");
  end

  logic [15:0] base_ff;
  logic straps_taken_ff;
  pnp_cfg_pkg::test_mode_t test_mode_ff;
  logic [7:0] pointer_ff;
  logic [7:0] logical_unit_number;
  logic [7:0] unit_ff;
  logic [NUM_BANKS-1:0] act_ff;
  logic [7:0] bhi_ff [NUM_BANKS];
  logic [7:0] blo_ff [NUM_BANKS];
  logic [3:0] irq_ff [NUM_BANKS];
  logic [NUM_BANKS-1:0] pol_ff;
  logic [NUM_BANKS-1:0] typ_ff;
  logic [2:0] dma0_ff [NUM_BANKS];
  logic [2:0] dma1_ff [NUM_BANKS];
  logic [7:0] io_rdata_ff;
  logic hit_index;
  logic hit_data;
  logic wr_data;
  logic bank_ok;
  logic [1:0] bank_sel;
  logic [7:0] nxt_rdata;

  assign logical_unit_number = unit_ff;

  // Straps are caught on the first clock after reset release, never under reset.
  // strap sampling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      straps_taken_ff <= 1'b0;
      base_ff <= `ADDR_PAIR_HIGH;
      test_mode_ff <= pnp_cfg_pkg::test_normal;
    end else if (!straps_taken_ff) begin
      straps_taken_ff <= 1'b1;
      base_ff <= config_base_strap ? `ADDR_PAIR_HIGH : `ADDR_PAIR_LOW;
      case ({test_strap, float_select_strap})
        2'b11: test_mode_ff <= pnp_cfg_pkg::test_normal;
        2'b10: test_mode_ff <= pnp_cfg_pkg::test_float;
        2'b01: test_mode_ff <= pnp_cfg_pkg::test_xor;
        default: test_mode_ff <= pnp_cfg_pkg::test_reserved;
      endcase
    end
  end

  always_comb begin
    hit_index = 1'b0;
    hit_data = 1'b0;
    if (io_valid && straps_taken_ff && io_addr == base_ff) begin
      hit_index = 1'b1;
    end else if (io_valid && straps_taken_ff && io_addr == base_ff + 16'h0001) begin
      hit_data = 1'b1;
    end
  end
  assign io_claim = hit_index | hit_data;
  assign wr_data = hit_data & io_write;

  always_comb begin
    bank_ok = 1'b1;
    bank_sel = 2'd0;
    if (logical_unit_number == `UNIT_FIR_SP2) begin
      bank_sel = 2'(pnp_cfg_pkg::bank_fir_sp2);
    end else if (logical_unit_number == `UNIT_SP1) begin
      bank_sel = 2'(pnp_cfg_pkg::bank_sp1);
    end else if (logical_unit_number == `UNIT_GPIO) begin
      bank_sel = 2'(pnp_cfg_pkg::bank_gpio);
    end else begin
      bank_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pointer_ff <= `RST_POINTER;
    end else if (hit_index && io_write) begin
      pointer_ff <= io_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unit_ff <= `RST_UNIT;
    end else if (wr_data && pointer_ff == `IDX_UNIT_SELECT) begin
      unit_ff <= io_wdata;
    end
  end

  // The fourth bank is unreachable until a unit number maps to it.
  // four duplicated banks
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      logic sel;
      assign sel = wr_data && bank_ok && bank_sel == 2'(g);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          act_ff[g] <= 1'b0;
          bhi_ff[g] <= 8'h00;
          blo_ff[g] <= 8'h00;
          irq_ff[g] <= 4'h0;
          pol_ff[g] <= 1'b0;
          typ_ff[g] <= FIXED_TYPE_VAL[g];
          dma0_ff[g] <= `RST_DMA;
          dma1_ff[g] <= `RST_DMA;
        end else if (sel) begin
          if (pointer_ff == `IDX_ACTIVATE) begin
            act_ff[g] <= io_wdata[`BIT_ACTIVATE];
          end
          if (pointer_ff == `IDX_BASE_HIGH) begin
            bhi_ff[g] <= io_wdata;
          end
          if (pointer_ff == `IDX_BASE_LOW) begin
            blo_ff[g] <= io_wdata;
          end
          if (pointer_ff == `IDX_IRQ_NUMBER) begin
            irq_ff[g] <= io_wdata[3:0];
          end
          if (pointer_ff == `IDX_IRQ_TYPE) begin
            pol_ff[g] <= io_wdata[`BIT_IRQ_POL];
            if (!FIXED_TYPE[g]) begin
              typ_ff[g] <= io_wdata[`BIT_IRQ_TYPE];
            end
          end
          // Reserved values 5 to 7 are stored as written; the host must not use them.
          // first and second DMA channels
          if (pointer_ff == `IDX_DMA_FIRST) begin
            dma0_ff[g] <= io_wdata[2:0];
          end
          if (pointer_ff == `IDX_DMA_SECOND) begin
            dma1_ff[g] <= io_wdata[2:0];
          end
        end
      end
      // IRQ number and DMA channels are detached while the unit is inactive; base and IRQ type pass through.
      // IRQ number and DMA follow activation
      assign unit_active[g] = act_ff[g];
      assign unit_io_base[g*16 +: 16] = {bhi_ff[g], blo_ff[g]};
      assign unit_irq_num[g*4 +: 4] = act_ff[g] ? irq_ff[g] : 4'h0;
      assign unit_irq_pol[g] = pol_ff[g];
      assign unit_irq_level[g] = typ_ff[g];
      assign unit_dma0[g*3 +: 3] = act_ff[g] ? dma0_ff[g] : `RST_DMA;
      assign unit_dma1[g*3 +: 3] = act_ff[g] ? dma1_ff[g] : `RST_DMA;
    end
  endgenerate

  // Read mux; bank registers stay readable whatever the activation state.
  // data port access
  always_comb begin
    nxt_rdata = `RD_UNMAPPED;
    if (hit_index) begin
      nxt_rdata = pointer_ff;
    end else if (pointer_ff == `IDX_UNIT_SELECT) begin
      nxt_rdata = unit_ff;
    end else if (pointer_ff >= `IDX_BANK_START && !bank_ok) begin
      if (pointer_ff == `IDX_DMA_FIRST || pointer_ff == `IDX_DMA_SECOND) begin
        nxt_rdata = `RD_NO_DMA;
      end
    end else if (pointer_ff == `IDX_ACTIVATE) begin
      nxt_rdata = {7'h00, act_ff[bank_sel]};
    end else if (pointer_ff == `IDX_BASE_HIGH) begin
      nxt_rdata = bhi_ff[bank_sel];
    end else if (pointer_ff == `IDX_BASE_LOW) begin
      nxt_rdata = blo_ff[bank_sel];
    end else if (pointer_ff == `IDX_IRQ_NUMBER) begin
      nxt_rdata = {4'h0, irq_ff[bank_sel]};
    end else if (pointer_ff == `IDX_IRQ_TYPE) begin
      nxt_rdata = {6'h00, pol_ff[bank_sel], typ_ff[bank_sel]};
    end else if (pointer_ff == `IDX_DMA_FIRST) begin
      nxt_rdata = {5'h00, dma0_ff[bank_sel]};
    end else if (pointer_ff == `IDX_DMA_SECOND) begin
      nxt_rdata = {5'h00, dma1_ff[bank_sel]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_rdata_ff <= 8'h00;
    end else if (io_claim && !io_write) begin
      io_rdata_ff <= nxt_rdata;
    end
  end
  assign io_rdata = io_rdata_ff;

  // The chain is combinational so the board sees pin changes without a clock.
  // test mode and base address outputs
  assign all_pins_floated_mode = test_mode_ff == pnp_cfg_pkg::test_float;
  assign xor_mode = test_mode_ff == pnp_cfg_pkg::test_xor;
  assign xor_out = xor_mode ? ^xor_chain_in : 1'b0;
  assign cfg_base_addr = base_ff;

endmodule : pnp_config_register_file
`default_nettype wire

// File: verification/pnp_cfg_chk.sv
// Port checker for the configuration register file.
`timescale 1ns/1ps
`default_nettype none
module pnp_cfg_chk #(
  parameter int NUM_BANKS = 4,
  parameter int XOR_PINS = 16
) (
  // Clock, reset and host cycle.
  input wire logic mclk,
  input wire logic rst,
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_claim,
  input wire logic [7:0] io_rdata,
  // Unit resources and test modes.
  input wire logic [NUM_BANKS-1:0] unit_active,
  input wire logic [NUM_BANKS*4-1:0] unit_irq_num,
  input wire logic [NUM_BANKS*3-1:0] unit_dma0,
  input wire logic [NUM_BANKS*3-1:0] unit_dma1,
  input wire logic [XOR_PINS-1:0] xor_chain_in,
  input wire logic all_pins_floated_mode,
  input wire logic xor_mode,
  input wire logic xor_out,
  input wire logic [15:0] cfg_base_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic hit = io_valid && io_addr[15:1] == cfg_base_addr[15:1];
  AST_CLAIM: assert property (hit |-> io_claim)
    else $error("pair access not claimed");
  AST_NO_CLAIM: assert property (!hit |-> !io_claim)
    else $error("foreign address claimed");
  AST_BASE: assert property (cfg_base_addr == 16'h002e || cfg_base_addr == 16'h164e)
    else $error("bad pair address");
  AST_PTR: assert property (hit && io_write && !io_addr[0] ##2 hit && !io_write && !io_addr[0]
    |=> io_rdata == $past(io_wdata, 3))
    else $error("pointer readback wrong");
  AST_RDATA_HOLD: assert property (!(hit && !io_write) |=> $stable(io_rdata))
    else $error("read data moved without read");
  AST_XOR: assert property (xor_out == (xor_mode ? ^xor_chain_in : 1'b0))
    else $error("chain output wrong");
  AST_MODE_EXCL: assert property (!(all_pins_floated_mode && xor_mode))
    else $error("two test modes at once");
  AST_MODE_HOLD: assert property (!$past(rst) && !$past(rst, 2)
    |-> $stable({xor_mode, all_pins_floated_mode}))
    else $error("test mode changed after capture");
  AST_MASK: assert property (!unit_active[0] |-> unit_irq_num[3:0] == 4'h0
    && unit_dma0[2:0] == 3'h4 && unit_dma1[2:0] == 3'h4)
    else $error("inactive unit holds resources");
  AST_BANK_SPARE: assert property (!unit_active[NUM_BANKS-1])
    else $error("spare bank activated");
  cover property (hit && !io_write);
  cover property (xor_mode);
  cover property (all_pins_floated_mode);
  cover property (unit_active[2]);
endmodule : pnp_cfg_chk
`default_nettype wire

// File: verification/pnp_cfg_host.sv
// Host model issuing single-byte configuration I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module pnp_cfg_host (
  // Clock.
  input wire logic mclk,
  // Byte I/O cycle.
  output logic io_valid,
  output logic io_write,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(negedge mclk);
    io_valid = 1'b1;
    io_write = wr;
    io_addr = addr;
    io_wdata = data;
    @(negedge mclk);
    // Released lines show the inverse so a stale value never passes for a fresh one.
    io_valid = 1'b0;
    io_write = ~wr;
    io_addr = ~addr;
    io_wdata = ~data;
  endtask : xfer
endmodule : pnp_cfg_host
`default_nettype wire

// File: verification/pnp_config_register_file_bench.sv
// Self-checking bench for the configuration register file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module pnp_config_register_file_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic config_base_strap = 1'b1, test_strap = 1'b1, float_select_strap = 1'b1;
  logic io_valid, io_write, io_claim, all_pins_floated_mode, xor_mode, xor_out;
  logic [15:0] io_addr, cfg_base_addr, base;
  logic [15:0] xor_chain_in = 16'h0000;
  logic [7:0] io_wdata, io_rdata;
  logic [3:0] unit_active, unit_irq_pol, unit_irq_level;
  logic [63:0] unit_io_base;
  logic [15:0] unit_irq_num;
  logic [11:0] unit_dma0, unit_dma1;
  logic [7:0] expq[$];
  logic [7:0] val[3][7];
  logic [7:0] idx[7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75};
  logic [7:0] msk[7] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'h03, 8'h07, 8'h07};
  int fail_count = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  pnp_cfg_host host_u (.mclk, .io_valid, .io_write, .io_addr, .io_wdata);
  pnp_config_register_file dut_u (.mclk, .rst, .config_base_strap, .test_strap,
    .float_select_strap, .io_valid, .io_write, .io_addr, .io_wdata, .io_claim, .io_rdata,
    .unit_active, .unit_io_base, .unit_irq_num, .unit_irq_pol, .unit_irq_level, .unit_dma0,
    .unit_dma1, .xor_chain_in, .all_pins_floated_mode, .xor_mode, .xor_out, .cfg_base_addr);
  function automatic logic [7:0] unit(int g);
    return (g == 0) ? 8'h02 : (g == 1) ? 8'h03 : 8'h07;
  endfunction : unit
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic boot(input logic b, input logic t, input logic f);
    rst = 1'b1;
    config_base_strap = b;
    test_strap = t;
    float_select_strap = f;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    base = b ? 16'h164e : 16'h002e;
  endtask : boot
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host_u.xfer(1'b1, base, i);
    host_u.xfer(1'b1, base + 16'h0001, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    host_u.xfer(1'b1, base, i);
    expq.push_back(e);
    host_u.xfer(1'b0, base + 16'h0001, 8'h00);
  endtask : rd
  // The read result is registered on the same edge that samples the claimed cycle.
  always @(posedge mclk) begin
    if (io_valid && io_claim && !io_write) begin
      #1;
      `CHK(io_rdata, expq.pop_front())
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'hd592ce88));
    for (int m = 2; m >= 0; m--) begin
      boot(m == 0, m != 2, m != 1);
      `CHK({all_pins_floated_mode, xor_mode}, {m == 1, m == 2})
      `CHK(cfg_base_addr, base)
      `CHK(unit_dma0, {4{3'h4}})
      xor_chain_in = 16'($urandom());
      #1 `CHK(xor_out, (m == 2) ? ^xor_chain_in : 1'b0)
      expq.push_back(8'h00);
      host_u.xfer(1'b0, base, 8'h00);
    end
    host_u.xfer(1'b1, base, 8'h75);
    expq.push_back(8'h75);
    host_u.xfer(1'b0, base, 8'h00);
    for (int g = 0; g < 3; g++) begin
      for (int k = 0; k < 7; k++) val[g][k] = 8'($urandom());
      val[g][0][0] = (g != 1);
      val[g][3][3:0] = 4'(g + 1);
      val[g][5][2:0] = 3'(g);
      val[g][6][2:0] = (g == 0) ? 3'h3 : 3'h4;
      wr(8'h07, unit(g));
      rd(8'h07, unit(g));
      for (int k = 0; k < 7; k++) wr(idx[k], val[g][k]);
    end
    for (int g = 0; g < 3; g++) begin
      wr(8'h07, unit(g));
      for (int k = 0; k < 7; k++) rd(idx[k], val[g][k] & msk[k]);
      `CHK(unit_active[g], val[g][0][0])
      `CHK(unit_io_base[g*16+:16], {val[g][1], val[g][2]})
      `CHK(unit_irq_num[g*4+:4], val[g][0][0] ? val[g][3][3:0] : 4'h0)
      `CHK({unit_irq_pol[g], unit_irq_level[g]}, val[g][4][1:0])
      `CHK(unit_dma0[g*3+:3], val[g][0][0] ? val[g][5][2:0] : 3'h4)
      `CHK(unit_dma1[g*3+:3], val[g][0][0] ? val[g][6][2:0] : 3'h4)
    end
    wr(8'h07, 8'h05);
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h00);
    rd(8'h74, 8'h04);
    rd(8'h75, 8'h04);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    host_u.xfer(1'b0, base + 16'h0002, 8'h00);
    boot(1'b1, 1'b1, 1'b1);
    `CHK(unit_active, 4'h0)
    `CHK(unit_io_base, 64'h0)
    `CHK(expq.size(), 0)
    conclude();
  end
endmodule : pnp_config_register_file_bench
bind pnp_config_register_file pnp_cfg_chk #(.NUM_BANKS(NUM_BANKS), .XOR_PINS(XOR_PINS)) chk_u (
  .mclk, .rst, .io_valid, .io_write, .io_addr, .io_wdata, .io_claim, .io_rdata, .unit_active,
  .unit_irq_num, .unit_dma0, .unit_dma1, .xor_chain_in, .all_pins_floated_mode, .xor_mode,
  .xor_out, .cfg_base_addr);
`default_nettype wire
